// ==== include/spi_port_pkg.sv ====
package spi_port_pkg;
    localparam int AXI_ADDR_W = 4;
    localparam logic [AXI_ADDR_W-1:0] ADDR_MODE = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] ADDR_FORMAT = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] ADDR_DATA = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // spi_control_mode fields
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int ON_BIT = 1;
    localparam int INCOMPLETE_BIT = 0;
    localparam logic [7:0] MODE_WMASK = 8'hEF;
    localparam logic [7:0] MODE_RST = 8'hE0;
    // spi_control_format fields
    localparam int IDLE_BIT = 5;
    localparam int EDGE_BIT = 4;
    localparam int ORDER_BIT = 3;
    localparam int SELEN_BIT = 2;
    localparam int WRITE_COLLISION_FLAG_BIT = 1;
    localparam int DONE_BIT = 0;
    localparam logic [7:0] FORMAT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // module_mode_field codes
    localparam logic [2:0] MODE_DIV4 = 3'h0;
    localparam logic [2:0] MODE_DIV16 = 3'h1;
    localparam logic [2:0] MODE_DIV64 = 3'h2;
    localparam logic [2:0] MODE_TIMEBASE = 3'h3;
    localparam logic [2:0] MODE_TIMER = 3'h4;
    localparam logic [2:0] MODE_SLAVE = 3'h5;
    localparam logic [2:0] MODE_I2C = 3'h6;
    localparam logic [2:0] MODE_UNUSED = 3'h7;
    // aclk cycles per half serial clock period
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef struct packed {
        logic sck;
        logic sdo;
        logic cs_n;
    } pins_s;

    typedef struct packed {
        logic sdi;
        logic sdo;
        logic sck;
        logic cs_n;
    } pull_s;

    typedef enum {M_IDLE, M_RUN, M_DRAIN} mstate_e;
endpackage

// ==== rtl/serial_module_spi_port.sv ====
`timescale 1ns/10ps
// Functional notes
// - Four lines: data in, out, clock, select
// - Full duplex: shift out while shifting in
// - Master starts transfers and drives clock
// - Mode field bits 7..5 selects function
// - Bit 1 switches the whole module on
// - Select enable 1 uses pin, 0 floats
// - Bit 3 picks MSB-first or LSB-first
// - Capture on rising or falling edge
// - Format register bit layout 5..0
// - Pin directions follow mode, on, select enable
// - Only data and two control registers used
// - Pull-ups on enabled input pins only
// - Mode codes choose master rate or slave
// - Done flag set by hardware, software clears
// - Busy data write dropped, collision flag set
// - Idle level and edge choose capture edge
module serial_module_spi_port
    import spi_port_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // reset, synchronous except for the slave-side rx_l and done toggle, which reset asynchronously
    input wire logic [AXI_ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [AXI_ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic link_sck, // serial clock pin in, clocks slave mode
    input wire logic sdi_in, // serial data in pin
    input wire logic cs_n_in, // slave select pin in
    input wire logic timebase_tick, // timebase_clock half-period pulse
    input wire logic timer_match_tick, // compact_timer_one match pulse
    input wire pull_s pullup_select, // pull-up control settings
    output pins_s pin_out, // pin output levels
    output pins_s pin_oe, // pin output enables
    output pull_s pullup_en // pull-up switched in
);
    logic [7:0] mode_reg_r;
    logic [7:0] fmt_reg_r;
    logic [7:0] data_r;
    logic awready_r, wready_r, aw_got_r, w_got_r, bvalid_r, arready_r, rvalid_r;
    logic [AXI_ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [1:0] cs_sync_r, sdi_sync_r;
    logic [2:0] done_sync_r;
    logic slave_busy_d_r, s_pending_r;
    mstate_e mstate_r;
    logic [7:0] tx_sr_r, rx_sr_r;
    logic [4:0] m_edge_r;
    logic [5:0] div_r;
    logic sck_r, sdo_r, cs_r;
    logic [2:0] cap_d_r;
    logic [3:0] fin_d_r;
    pins_s pin_r, oe_r;
    pull_s pull_r;
    logic [2:0] cnt_l;
    logic [7:0] sr_l, rx_l;
    logic done_tog_l, first_l, sdo_l;

    function automatic logic out_bit(input logic [7:0] x, input logic msb);
        out_bit = msb ? x[7] : x[0];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] x, input logic b,
                                            input logic msb);
        shift_in = msb ? {x[6:0], b} : {b, x[7:1]};
    endfunction

    wire [2:0] mode = mode_reg_r[MODE_MSB:MODE_LSB];
    wire on = mode_reg_r[ON_BIT];
    wire msb_first = fmt_reg_r[ORDER_BIT];
    wire sel_en = fmt_reg_r[SELEN_BIT];
    wire master_en = on & (mode < MODE_SLAVE);
    wire slave_en = on & (mode == MODE_SLAVE);
    // idle high with edge 0, or idle low with edge 1, captures on rising
    wire cap_rise = fmt_reg_r[IDLE_BIT] == fmt_reg_r[EDGE_BIT];
    wire slave_busy = slave_en & sel_en & ~cs_sync_r[1];
    wire m_busy = mstate_r != M_IDLE;
    wire xfer_busy = m_busy | slave_busy;

    // register bus
    wire do_wr = aw_got_r & w_got_r & ~bvalid_r;
    wire wr_ok = do_wr & wstrb0_r;
    wire wr_mode = wr_ok & (awaddr_r == ADDR_MODE);
    wire wr_fmt = wr_ok & (awaddr_r == ADDR_FORMAT);
    wire wr_data = wr_ok & (awaddr_r == ADDR_DATA);
    wire aw_hit = awaddr_r == ADDR_MODE || awaddr_r == ADDR_FORMAT || awaddr_r == ADDR_DATA;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
        end
        else if (awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b1;
            awaddr_r <= awaddr;
        end
        else
        begin
            if (do_wr)
                aw_got_r <= 1'b0;
            if (!aw_got_r && !bvalid_r)
                awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_r <= 1'b0;
            w_got_r <= 1'b0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end
        else if (wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            w_got_r <= 1'b1;
            wdata_r <= wdata[7:0];
            wstrb0_r <= wstrb[0];
        end
        else
        begin
            if (do_wr)
                w_got_r <= 1'b0;
            if (!w_got_r && !bvalid_r)
                wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (do_wr)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= aw_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid_r <= 1'b0;
    end

    // no side effect on read: the data register reads back without clearing flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (araddr)
                ADDR_MODE: rdata_r <= {24'h000000, mode_reg_r};
                ADDR_FORMAT: rdata_r <= {24'h000000, fmt_reg_r};
                ADDR_DATA: rdata_r <= {24'h000000, data_r};
                default:
                begin
                    rdata_r <= '0;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
        else if (!rvalid_r)
            arready_r <= 1'b1;
    end

    // synchronisers and slave-side events
    wire s_done = done_sync_r[2] ^ done_sync_r[1];
    wire s_incomplete = slave_busy_d_r & ~slave_busy & s_pending_r & ~s_done;
    wire m_done = fin_d_r[3];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cs_sync_r <= 2'h3;
            sdi_sync_r <= 2'h0;
            done_sync_r <= 3'h0;
            slave_busy_d_r <= 1'b0;
            s_pending_r <= 1'b0;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], cs_n_in};
            sdi_sync_r <= {sdi_sync_r[0], sdi_in};
            done_sync_r <= {done_sync_r[1:0], done_tog_l};
            slave_busy_d_r <= slave_busy;
            if (slave_busy && !slave_busy_d_r)
                s_pending_r <= 1'b1;
            else if (s_done || !slave_busy)
                s_pending_r <= 1'b0;
        end
    end

    // control registers; a hardware set wins over a software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode_reg_r <= MODE_RST;
        else
        begin
            if (wr_mode)
                mode_reg_r <= wdata_r & MODE_WMASK;
            if (s_incomplete)
                mode_reg_r[INCOMPLETE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fmt_reg_r <= FORMAT_RST;
        else
        begin
            if (wr_fmt)
                fmt_reg_r <= wdata_r;
            if (m_done || s_done || s_incomplete)
                fmt_reg_r[DONE_BIT] <= 1'b1;
            if (wr_data && xfer_busy)
                fmt_reg_r[WRITE_COLLISION_FLAG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            data_r <= DATA_RST;
        else if (wr_data && !xfer_busy)
            data_r <= wdata_r;
        else if (m_done)
            data_r <= rx_sr_r;
        else if (s_done)
            data_r <= rx_l;
    end

    // master engine: clock from a divider of aclk or from the timebase and timer ticks, so it stays in this domain
    logic [5:0] half;
    logic tick;
    always_comb
    begin
        half = HALF_DIV4;
        tick = 1'b0;
        case (mode)
            MODE_DIV4, MODE_DIV16, MODE_DIV64:
            begin
                half = (mode == MODE_DIV4) ? HALF_DIV4 :
                       (mode == MODE_DIV16) ? HALF_DIV16 : HALF_DIV64;
                tick = div_r == half - 6'h01;
            end
            MODE_TIMEBASE: tick = timebase_tick;
            MODE_TIMER: tick = timer_match_tick;
            default: tick = 1'b0;
        endcase
    end

    wire m_start = wr_data & ~xfer_busy & master_en;
    wire run_tick = (mstate_r == M_RUN) & tick;
    wire is_cap = (~sck_r) == cap_rise;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || mstate_r != M_RUN || tick)
            div_r <= 6'h00;
        else
            div_r <= div_r + 6'h01;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mstate_r <= M_IDLE;
            m_edge_r <= 5'h00;
            sck_r <= 1'b1;
            cs_r <= 1'b1;
        end
        else
        begin
            case (mstate_r)
                M_IDLE:
                begin
                    sck_r <= ~fmt_reg_r[IDLE_BIT];
                    m_edge_r <= 5'h00;
                    if (m_start)
                    begin
                        mstate_r <= M_RUN;
                        cs_r <= 1'b0;
                    end
                end
                M_RUN:
                    if (!master_en)
                    begin
                        mstate_r <= M_IDLE;
                        cs_r <= 1'b1;
                    end
                    else if (tick)
                    begin
                        sck_r <= ~sck_r;
                        m_edge_r <= m_edge_r + 5'h01;
                        if (m_edge_r == LAST_EDGE)
                            mstate_r <= M_DRAIN;
                    end
                M_DRAIN:
                    if (m_done)
                    begin
                        mstate_r <= M_IDLE;
                        cs_r <= 1'b1;
                    end
                default: mstate_r <= M_IDLE;
            endcase
        end
    end

    // sdi is read through the synchroniser and the pin register, so capture
    // is acted on three cycles after the capture edge; the tail waits for it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_d_r <= 3'h0;
            fin_d_r <= 4'h0;
        end
        else
        begin
            cap_d_r <= {cap_d_r[1:0], run_tick & is_cap};
            fin_d_r <= {fin_d_r[2:0], run_tick & (m_edge_r == LAST_EDGE)};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_sr_r <= 8'h00;
            sdo_r <= 1'b0;
        end
        else if (m_start)
        begin
            tx_sr_r <= wdata_r;
            sdo_r <= out_bit(wdata_r, msb_first);
        end
        else if (run_tick && !is_cap && m_edge_r != 5'h00)
        begin
            tx_sr_r <= msb_first ? {tx_sr_r[6:0], 1'b0} : {1'b0, tx_sr_r[7:1]};
            sdo_r <= msb_first ? tx_sr_r[6] : tx_sr_r[1];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_sr_r <= 8'h00;
        else if (cap_d_r[2])
            rx_sr_r <= shift_in(rx_sr_r, sdi_sync_r[1], msb_first);
    end

    // slave engine on the link clock; config bits must be static during a
    // frame, since flipping the capture edge mid-frame glitches this clock
    wire slv_clk = link_sck ^ ~cap_rise;
    wire frame_end = ~slave_en | (sel_en & cs_n_in);
    wire [7:0] slv_base = (cnt_l == 3'h0) ? data_r : sr_l;
    wire [7:0] slv_next = shift_in(slv_base, sdi_in, msb_first);

    always_ff @(posedge slv_clk or posedge frame_end)
    begin
        if (frame_end)
        begin
            cnt_l <= 3'h0;
            sr_l <= 8'h00;
        end
        else
        begin
            cnt_l <= cnt_l + 3'h1;
            sr_l <= slv_next;
        end
    end

    // rx_l holds until the next byte ends; the aclk side copies it on the toggle
    always_ff @(posedge slv_clk or negedge aresetn)
    begin
        if (!aresetn)
        begin
            done_tog_l <= 1'b0;
            rx_l <= 8'h00;
        end
        else if (!frame_end && cnt_l == LAST_BIT)
        begin
            done_tog_l <= ~done_tog_l;
            rx_l <= slv_next;
        end
    end

    always_ff @(negedge slv_clk or posedge frame_end)
    begin
        if (frame_end)
        begin
            first_l <= 1'b1;
            sdo_l <= 1'b0;
        end
        else
        begin
            first_l <= cnt_l == 3'h0;
            sdo_l <= out_bit(sr_l, msb_first);
        end
    end

    // pins: directions follow mode, on and select enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_r <= '{sck: 1'b1, sdo: 1'b0, cs_n: 1'b1};
            oe_r <= '0;
            pull_r <= '0;
        end
        else
        begin
            pin_r <= '{sck: sck_r, sdo: sdo_r, cs_n: cs_r};
            oe_r <= '{sck: master_en, sdo: master_en | (slave_en & (~sel_en | ~cs_sync_r[1])),
                      cs_n: master_en & sel_en};
            pull_r <= pullup_select & pull_s'{sdi: master_en | slave_en, sdo: 1'b0,
                      sck: slave_en, cs_n: slave_en & sel_en};
        end
    end

    // the slave data bit must follow the link clock, so it bypasses pin_r
    assign pin_out = '{sck: pin_r.sck,
                       sdo: slave_en ? (first_l ? out_bit(data_r, msb_first) : sdo_l)
                                     : pin_r.sdo,
                       cs_n: pin_r.cs_n};
    assign pin_oe = oe_r;
    assign pullup_en = pull_r;
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
endmodule

// ==== tb/spi_port_monitor.sv ====
`timescale 1ns/10ps
module spi_port_monitor
    import spi_port_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic awready, // aw ready
    input wire logic wready, // w ready
    input wire logic awvalid, // aw valid
    input wire logic wvalid, // w valid
    input wire logic [1:0] bresp, // b resp
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // r data
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire pins_s pin_out, // pins
    input wire pins_s pin_oe, // enables
    input wire pull_s pullup_en // pull-ups
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic sck_q_r;
    logic [4:0] edges_r;
    always_ff @(posedge aclk)
        sck_q_r <= pin_out.sck;
    // toggles seen while the select pin is low
    always_ff @(posedge aclk)
        if (!aresetn || pin_out.cs_n)
            edges_r <= 5'h00;
        else if (pin_out.sck != sck_q_r)
            edges_r <= edges_r + 5'h01;
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response not held");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_w_take;
        awvalid && awready && wvalid && wready |=> !awready && !wready ##[0:2] bvalid;
    endproperty
    a_w_take: assert property (p_w_take)
        else $error("write not answered in time");
    property p_r_take;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_r_take: assert property (p_r_take)
        else $error("read not answered in time");
    property p_pull_in;
        !(pullup_en.sdo && pin_oe.sdo) && !(pullup_en.sck && pin_oe.sck);
    endproperty
    a_pull_in: assert property (p_pull_in)
        else $error("pull-up on a driven pin");
    property p_cs_frame;
        $fell(pin_out.cs_n) && pin_oe.cs_n |-> !pin_out.cs_n [*8];
    endproperty
    a_cs_frame: assert property (p_cs_frame)
        else $error("select pulse too short");
    property p_sck_half;
        $changed(pin_out.sck) && pin_oe.sck |=> $stable(pin_out.sck);
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("serial clock faster than system clock over four");
    property p_edges;
        $rose(pin_out.cs_n) && pin_oe.cs_n && pin_oe.sck |-> edges_r == 5'h10;
    endproperty
    a_edges: assert property (p_edges)
        else $error("frame without sixteen clock edges");
    c_frame: cover property ($rose(pin_out.cs_n) && pin_oe.cs_n);
    c_slverr: cover property (bvalid && bready && bresp == RESP_SLVERR);
    c_read: cover property (rvalid && rready);
endmodule
bind serial_module_spi_port spi_port_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .awready(awready), .wready(wready), .awvalid(awvalid), .wvalid(wvalid), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));

// ==== tb/spi_slave_model.sv ====
`timescale 1ns/10ps
module spi_slave_model
(
    input wire logic sck, // clock line
    input wire logic sdo, // device data out
    input wire logic cs_n, // select line
    input wire logic cap_rise, // capture on rising edge
    input wire logic msb, // msb first
    input wire logic [7:0] tx, // byte to return
    output logic sdi, // data to device
    output logic [7:0] rx // byte received
);
    logic [7:0] sh;
    int n;
    wire cap = cap_rise ? sck : ~sck;
    initial sdi = 1'b0;
    initial rx = 8'h00;
    always @(negedge cs_n)
    begin
        sh = tx;
        n = 0;
        sdi = msb ? tx[7] : tx[0];
    end
    always @(posedge cap)
        if (!cs_n)
        begin
            rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
            n++;
        end
    // a launch edge ahead of the first capture must not shift
    always @(negedge cap)
        if (!cs_n && n > 0 && n < 8)
        begin
            sh = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
            sdi = msb ? sh[7] : sh[0];
        end
    // released line shows the inverse so a stale bit cannot pass
    always @(posedge cs_n)
        sdi = ~sdi;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench
    import spi_port_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, m_sdi;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata;
    logic tbk = 1'b0, tmk = 1'b0, slv = 1'b0, gpio_cs = 1'b1, tb_sck = 1'b0, tb_sdi = 1'b0;
    logic cap_rise = 1'b1, msb = 1'b1;
    logic [7:0] stx = 8'h00;
    logic [7:0] srx;
    pull_s pullup_select = 4'hF;
    pins_s pin_out, pin_oe;
    pull_s pullup_en;
    int err_count = 0, num_checks = 0, cyc = 0;
    // clock and select follow whoever enables them, the bench otherwise; slv picks the sdi source
    wire sck_line = pin_oe.sck ? pin_out.sck : tb_sck;
    wire cs_line = pin_oe.cs_n ? pin_out.cs_n : gpio_cs;
    wire sdi_line = slv ? tb_sdi : m_sdi;
    serial_module_spi_port uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link_sck(sck_line), .sdi_in(sdi_line), .cs_n_in(cs_line),
        .timebase_tick(tbk), .timer_match_tick(tmk), .pullup_select(pullup_select),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));
    spi_slave_model peer (.sck(sck_line), .sdo(pin_out.sdo), .cs_n(cs_line), .cap_rise(cap_rise),
        .msb(msb), .tx(stx), .sdi(m_sdi), .rx(srx));
    initial
        forever #20 aclk = ~aclk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        tbk <= (cyc % 4 == 0);
        tmk <= (cyc % 3 == 0);
        if (cyc == 30000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // the device raises ready without waiting for valid; each valid drops once its own ready is seen
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid)
            @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        last_resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        araddr <= a;
        arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        while (!rvalid)
            @(posedge aclk);
        rready <= 1'b1;
        @(posedge aclk);
        v = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_reset();
        logic [31:0] v;
        rd(ADDR_MODE, v);
        chk(v, {24'h0, MODE_RST});
        rd(ADDR_FORMAT, v);
        chk(v, {24'h0, FORMAT_RST});
        rd(ADDR_DATA, v);
        chk(v, {24'h0, DATA_RST});
        chk({29'h0, pin_oe}, 32'h0);
        rd(4'hC, v);
        chk({v[29:0], last_resp}, {30'h0, RESP_SLVERR});
        wr(4'hC, 8'hFF);
        chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
        wr(ADDR_MODE, 8'hFF);
        rd(ADDR_MODE, v);
        chk(v, {24'h0, MODE_WMASK});
        wr(ADDR_MODE, MODE_RST);
        $display("reset test done");
    endtask
    task automatic t_master(input logic [2:0] code, input logic [7:0] fmt, input logic [7:0] tx,
        input logic [7:0] back);
        logic [31:0] v;
        int n;
        cap_rise = (fmt[IDLE_BIT] == fmt[EDGE_BIT]);
        msb = fmt[ORDER_BIT];
        stx = back;
        wr(ADDR_FORMAT, fmt);
        wr(ADDR_MODE, {code, 5'h02});
        chk({31'h0, pullup_en.sdi}, 32'h1);
        chk({31'h0, pin_oe.sck}, 32'h1);
        // with the select pin given up, software selects the peer by hand
        gpio_cs <= fmt[SELEN_BIT];
        wr(ADDR_DATA, tx);
        chk({31'h0, pin_oe.cs_n}, {31'h0, fmt[SELEN_BIT]});
        wr(ADDR_DATA, ~tx);
        n = 0;
        do
        begin
            rd(ADDR_FORMAT, v);
            n++;
        end
        while (v[DONE_BIT] !== 1'b1 && n < 300);
        chk(v, {24'h0, fmt | 8'h03});
        rd(ADDR_DATA, v);
        chk(v, {24'h0, back});
        chk({24'h0, srx}, {24'h0, tx});
        wr(ADDR_FORMAT, fmt);
        gpio_cs <= 1'b1;
        $display("master test mode %0d done", code);
    endtask
    task automatic t_slave(input int nb, input logic [7:0] em, input logic [7:0] ed);
        logic [31:0] v;
        logic [7:0] got;
        got = 8'h00;
        slv = 1'b1;
        wr(ADDR_FORMAT, 8'h3C);
        wr(ADDR_MODE, {MODE_SLAVE, 5'h02});
        wr(ADDR_DATA, 8'hA5);
        gpio_cs <= 1'b0;
        // two synchroniser stages plus the enable register, seen one edge later
        repeat (4) @(posedge aclk);
        chk({30'h0, pin_oe.sdo, pin_oe.sck}, 32'h2);
        for (int i = 0; i < nb; i++)
        begin
            tb_sdi = ed[7 - i];
            #3 got = {got[6:0], pin_out.sdo};
            tb_sck = 1'b1;
            #3 tb_sck = 1'b0;
        end
        @(posedge aclk);
        gpio_cs <= 1'b1;
        repeat (8) @(posedge aclk);
        if (nb == 8)
            chk({24'h0, got}, 32'hA5);
        rd(ADDR_MODE, v);
        chk(v, {24'h0, em});
        rd(ADDR_FORMAT, v);
        chk(v, 32'h3D);
        rd(ADDR_DATA, v);
        chk(v, {24'h0, ed});
        wr(ADDR_MODE, {MODE_SLAVE, 5'h02});
        wr(ADDR_FORMAT, 8'h3C);
        $display("slave test %0d bits done", nb);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_master(MODE_DIV4, 8'h0C, 8'hA5, 8'h3C);
        t_master(MODE_DIV16, 8'h14, 8'h96, 8'h5A);
        t_master(MODE_DIV64, 8'h28, 8'h81, 8'hC3);
        t_master(MODE_TIMEBASE, 8'h3C, 8'h1E, 8'h69);
        t_master(MODE_TIMER, 8'hC4, 8'h7E, 8'h18);
        t_slave(3, 8'hA3, 8'hA5);
        t_slave(8, 8'hA2, 8'h3C);
        report_and_stop();
    end
endmodule
